// ---- pkg/tecc_pkg.sv ----
package tecc_pkg;
  // Register byte offsets
  localparam logic [7:0] TECC_OFF_SWEVT = 8'h14;
  localparam logic [7:0] TECC_OFF_CHCTL = 8'h18;
  localparam logic [7:0] TECC_OFF_CMPV = 8'h1C;
  localparam logic [7:0] TECC_OFF_STAT = 8'h20;
  // Field positions
  localparam int TECC_UPD_BIT = 0;
  localparam int TECC_CHEV_BIT = 1;
  localparam int TECC_DIR_LSB = 0;
  localparam int TECC_FAST_BIT = 2;
  localparam int TECC_SHAD_BIT = 3;
  localparam int TECC_MODE_LSB = 4;
  localparam int TECC_FLT_LSB = 4;
  localparam int TECC_FLAG_BIT = 1;
  localparam int TECC_OVC_BIT = 9;
  // Writable mask of channel control
  localparam logic [31:0] TECC_CHCTL_MASK = 32'h000000FF;
  localparam logic [31:0] TECC_RESET = 32'h00000000;
  // Direction codes
  localparam logic [1:0] TECC_DIR_OUT = 2'h0;
  localparam logic [1:0] TECC_DIR_IN = 2'h1;
  // Output compare modes
  localparam logic [2:0] TECC_M_TIMING = 3'h0;
  localparam logic [2:0] TECC_M_SET = 3'h1;
  localparam logic [2:0] TECC_M_CLR = 3'h2;
  localparam logic [2:0] TECC_M_TOG = 3'h3;
  localparam logic [2:0] TECC_M_LOW = 3'h4;
  localparam logic [2:0] TECC_M_HIGH = 3'h5;
  localparam logic [2:0] TECC_M_PWM0 = 3'h6;
  localparam logic [2:0] TECC_M_PWM1 = 3'h7;
  // AXI responses
  localparam logic [1:0] TECC_RESP_OKAY = 2'h0;
  localparam logic [1:0] TECC_RESP_SLVERR = 2'h2;
endpackage : tecc_pkg

// ---- hw/tecc_outgen.sv ----
// Prepared output generator for channel 0
module tecc_outgen
  import tecc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] mode,
  input wire logic out_en,
  input wire logic fast_en,
  input wire logic trig_edge,
  input wire logic count_down,
  input wire logic [15:0] counter_value,
  input wire logic [15:0] cmp,
  output logic prepared_output
);
  import tecc_pkg::*;

  logic match; // Counter equals compare
  logic pwm_lvl; // Level a PWM mode asks for
  logic pwm_mode; // One of the two PWM codes
  logic out_d; // Level for the next edge

  assign match = (counter_value == cmp);
  assign pwm_mode = (mode == TECC_M_PWM0) || (mode == TECC_M_PWM1);

  // PWM levels follow compare; fast trigger forces the up-count compare level
  always_comb begin
    if (count_down) begin
      pwm_lvl = !(counter_value > cmp);
    end else begin
      pwm_lvl = (counter_value < cmp);
    end
    if (mode == TECC_M_PWM1) begin
      pwm_lvl = !pwm_lvl;
    end
    if (fast_en && trig_edge) begin
      pwm_lvl = (mode == TECC_M_PWM1);
    end
  end

  // Next level per mode
  always_comb begin
    out_d = prepared_output;
    if (out_en) begin
      case (mode)
        TECC_M_TIMING: out_d = prepared_output;
        TECC_M_SET: if (match) out_d = 1'b1;
        TECC_M_CLR: if (match) out_d = 1'b0;
        TECC_M_TOG: if (match) out_d = !prepared_output;
        TECC_M_LOW: out_d = 1'b0;
        TECC_M_HIGH: out_d = 1'b1;
        TECC_M_PWM0, TECC_M_PWM1: out_d = pwm_lvl;
        default: out_d = prepared_output;
      endcase
    end
  end

  // Registered so the level only moves when its cause does
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prepared_output <= 1'b0;
    end else begin
      prepared_output <= out_d;
    end
  end

  a_force_high: assert property (@(posedge aclk) disable iff (!aresetn)
    out_en && mode == TECC_M_HIGH |=> prepared_output)
    else $error("force high not applied");
  a_timing_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    out_en && mode == TECC_M_TIMING |=> $stable(prepared_output))
    else $error("timing mode moved output");
  a_toggle_match: assert property (@(posedge aclk) disable iff (!aresetn)
    out_en && mode == TECC_M_TOG && match |=> prepared_output != $past(prepared_output))
    else $error("toggle missed");
  a_pwm_change: assert property (@(posedge aclk) disable iff (!aresetn)
    out_en && pwm_mode && $stable(mode) && prepared_output == pwm_lvl
    && $stable(pwm_lvl) |=> $stable(prepared_output))
    else $error("pwm output moved without cause");
  // Fast trigger in PWM0 drives the up-count compare level, which is low
  a_fast_match: assert property (@(posedge aclk) disable iff (!aresetn)
    out_en && fast_en && trig_edge && mode == TECC_M_PWM0 |=> !prepared_output)
    else $error("fast trigger ignored");
endmodule : tecc_outgen

// ---- hw/tecc_core.sv ----
// Channel 0 event and compare control with AXI4-Lite registers
module tecc_core
  import tecc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] counter_value,
  input wire logic count_down,
  input wire logic chan_enable,
  input wire logic chan_irq_enable,
  input wire logic chan_dma_enable,
  input wire logic trig_edge,
  input wire logic hw_capcmp_event,
  input wire logic flag_clear,
  input wire logic ovc_clear,
  output logic update_event,
  output logic counter_clear,
  output logic chan_event,
  output logic chan_irq,
  output logic chan_dma_req,
  output logic chan_capcmp_flag,
  output logic chan_overcapture_flag,
  output logic [3:0] capture_filter,
  output logic [1:0] capture_prescaler,
  output logic prepared_output
);
  import tecc_pkg::*;

  // Address decode of word offsets
  function automatic logic [2:0] dec(input logic [7:0] a);
    dec = 3'h0;
    case ({a[7:2], 2'h0})
      TECC_OFF_SWEVT: dec = 3'h1;
      TECC_OFF_CHCTL: dec = 3'h2;
      TECC_OFF_CMPV: dec = 3'h3;
      TECC_OFF_STAT: dec = 3'h4;
      default: dec = 3'h0;
    endcase
  endfunction : dec

  logic aw_held_q; // Write address captured
  logic w_held_q; // Write data captured
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_wr; // Both halves present, response free
  logic do_rd;
  logic [31:0] chctl_q; // Channel mode control
  logic [15:0] cmp_pre_q; // Written compare value
  logic [15:0] cmp_act_q; // Active compare value
  logic [15:0] capture_q; // Captured counter
  logic [1:0] trig_q; // Self-clearing event bits
  logic flag_q;
  logic ovc_q;
  logic in_mode;
  logic cap_read; // Software reads capture value
  logic ev_any;

  // Readies fall while a half is held, so a held half is never overwritten
  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready = !w_held_q;
  assign do_wr = aw_held_q && w_held_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_rd = s_axi_arvalid && s_axi_arready;
  assign in_mode = (chctl_q[TECC_DIR_LSB +: 2] == TECC_DIR_IN);

  // Address and data are taken independently
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (do_wr) begin
      w_held_q <= 1'b0;
    end
  end

  // Write response; partial strobes refused since only words are legal
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TECC_RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (dec(awaddr_q) inside {3'h1, 3'h2, 3'h3} && wstrb_q == 4'hF)
        ? TECC_RESP_OKAY : TECC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only full-word writes land; anything else is answered and dropped
  logic wr_ok;
  assign wr_ok = do_wr && (wstrb_q == 4'hF);

  // Event trigger bits clear themselves one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_q <= 2'h0;
    end else if (wr_ok && dec(awaddr_q) == 3'h1) begin
      trig_q <= wdata_q[1:0];
    end else begin
      trig_q <= 2'h0;
    end
  end

  // The update pulse also clears counter and prescaler outside this block
  assign update_event = trig_q[TECC_UPD_BIT];
  assign counter_clear = trig_q[TECC_UPD_BIT];
  assign chan_event = trig_q[TECC_CHEV_BIT];
  assign ev_any = chan_event || hw_capcmp_event;

  // Channel control; direction locked while channel runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chctl_q <= TECC_RESET;
    end else if (wr_ok && dec(awaddr_q) == 3'h2) begin
      chctl_q[7:2] <= wdata_q[7:2];
      if (!chan_enable) begin
        chctl_q[1:0] <= wdata_q[1:0];
      end
    end
  end

  // Compare value, shadowed or direct
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_pre_q <= 16'h0000;
    end else if (wr_ok && dec(awaddr_q) == 3'h3 && !in_mode) begin
      cmp_pre_q <= wdata_q[15:0];
    end
  end

  // Shadow on: reload only at update; off: follow the written value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_act_q <= 16'h0000;
    end else if (!chctl_q[TECC_SHAD_BIT] || update_event) begin
      cmp_act_q <= cmp_pre_q;
    end
  end

  // Capture on event in input mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_q <= 16'h0000;
    end else if (in_mode && ev_any) begin
      capture_q <= counter_value;
    end
  end

  // A capture read in input mode clears the flag
  assign cap_read = do_rd && dec(s_axi_araddr) == 3'h3 && in_mode;

  // Flag: set wins over clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else if (ev_any) begin
      flag_q <= 1'b1;
    end else if (flag_clear || cap_read) begin
      flag_q <= 1'b0;
    end
  end

  // Overcapture only in input mode; a capture while the flag is set wins over a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovc_q <= 1'b0;
    end else if (in_mode && ev_any && flag_q) begin
      ovc_q <= 1'b1;
    end else if (ovc_clear) begin
      ovc_q <= 1'b0;
    end
  end

  // Interrupt is a level, the DMA request a one-cycle pulse per software channel event
  assign chan_capcmp_flag = flag_q;
  assign chan_overcapture_flag = ovc_q;
  assign chan_irq = flag_q && chan_irq_enable;
  assign chan_dma_req = chan_event && chan_dma_enable;
  assign capture_filter = in_mode ? chctl_q[TECC_FLT_LSB +: 4] : 4'h0;
  assign capture_prescaler = in_mode ? chctl_q[3:2] : 2'h0;

  // Read channel
  // Data is registered, so a capture read sees the value before this edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= TECC_RESP_OKAY;
    end else if (do_rd) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= TECC_RESP_OKAY;
      case (dec(s_axi_araddr))
        3'h1: s_axi_rdata <= 32'h00000000;
        3'h2: s_axi_rdata <= chctl_q & TECC_CHCTL_MASK;
        3'h3: s_axi_rdata <= {16'h0000, in_mode ? capture_q : cmp_pre_q};
        3'h4: s_axi_rdata <= {22'h000000, ovc_q, 7'h00, flag_q, 1'b0};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= TECC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Output stage follows the mode field and idles while the channel captures
  tecc_outgen u_outgen (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(chctl_q[TECC_MODE_LSB +: 3]),
    .out_en(!in_mode),
    .fast_en(chctl_q[TECC_FAST_BIT]),
    .trig_edge(trig_edge),
    .count_down(count_down),
    .counter_value(counter_value),
    .cmp(cmp_act_q),
    .prepared_output(prepared_output)
  );

  // Answers stand until the master takes them
  a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");

  a_rdata_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");

  // Trigger writes, and the one-cycle pulses they must leave behind
  sequence s_evt_write;
    wr_ok && dec(awaddr_q) == 3'h1 && wdata_q[TECC_CHEV_BIT];
  endsequence

  sequence s_evt_pulse;
    chan_event ##1 (!chan_event && flag_q);
  endsequence

  sequence s_upd_write;
    wr_ok && dec(awaddr_q) == 3'h1 && wdata_q[TECC_UPD_BIT];
  endsequence

  sequence s_upd_pulse;
    (update_event && counter_clear) ##1 !update_event;
  endsequence

  a_evt_steps: assert property (@(posedge aclk) disable iff (!aresetn)
    s_evt_write |=> s_evt_pulse)
    else $error("channel event pulse or flag wrong");

  a_upd_steps: assert property (@(posedge aclk) disable iff (!aresetn)
    s_upd_write |=> s_upd_pulse)
    else $error("update pulse wrong");

  // Flags, capture and direction lock
  a_trig_self: assert property (@(posedge aclk) disable iff (!aresetn)
    chan_event |=> !chan_event || $past(wr_ok))
    else $error("event bit did not clear");

  a_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
    chan_event |=> flag_q)
    else $error("flag not set by event");

  a_capture_val: assert property (@(posedge aclk) disable iff (!aresetn)
    in_mode && chan_event |=> capture_q == $past(counter_value))
    else $error("capture wrong");

  a_ovc_set: assert property (@(posedge aclk) disable iff (!aresetn)
    in_mode && ev_any && flag_q |=> ovc_q)
    else $error("overcapture missed");

  a_ovc_input: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(ovc_q) |-> $past(in_mode && ev_any && flag_q))
    else $error("overcapture without cause");

  a_dir_lock: assert property (@(posedge aclk) disable iff (!aresetn)
    chan_enable |=> $stable(chctl_q[1:0]))
    else $error("direction changed while enabled");

  a_direct_cmp: assert property (@(posedge aclk) disable iff (!aresetn)
    !chctl_q[TECC_SHAD_BIT] |=> cmp_act_q == $past(cmp_pre_q))
    else $error("direct compare not applied");

  a_shadow_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    chctl_q[TECC_SHAD_BIT] && !update_event |=> $stable(cmp_act_q))
    else $error("shadowed compare moved without update");

  a_upd_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    update_event |-> counter_clear)
    else $error("update without clear");

  a_cap_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    cap_read && !ev_any |=> !flag_q)
    else $error("capture read kept flag");

  // Register refusals and field visibility
  a_swevt_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    do_rd && dec(s_axi_araddr) == 3'h1 |=> s_axi_rvalid && s_axi_rdata == 32'h00000000)
    else $error("event register read not zero");

  a_strobe_refuse: assert property (@(posedge aclk) disable iff (!aresetn)
    do_wr && wstrb_q != 4'hF |=> s_axi_bresp == TECC_RESP_SLVERR && $stable(chctl_q))
    else $error("partial write not refused");

  a_filter_out: assert property (@(posedge aclk) disable iff (!aresetn)
    !in_mode |-> capture_filter == 4'h0 && capture_prescaler == 2'h0)
    else $error("capture fields shown in output mode");
endmodule : tecc_core

// ---- verification/tecc_core_tb.sv ----
module tecc_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tecc_pkg::*;
  // Bench signals share the core's port names so the instance hooks up by name
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [15:0] counter_value = 16'h0030;
  logic count_down = 1'h0, chan_enable = 1'h0, chan_irq_enable = 1'h0;
  logic chan_dma_enable = 1'h0, flag_clear = 1'h0;
  // Tied off: protection bits, external event, overcapture clear; trigger pulsed once
  logic trig_edge = 1'h0, hw_capcmp_event = 1'h0, ovc_clear = 1'h0;
  // Outputs of the core
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic update_event, counter_clear, chan_event, chan_irq, chan_dma_req;
  logic chan_capcmp_flag, chan_overcapture_flag, prepared_output;
  logic [3:0] capture_filter;
  logic [1:0] capture_prescaler;
  // Verdict bookkeeping
  int err_count = 0;
  int checked = 0;
  // Pulse tallies, kept per edge so one-cycle pulses are never missed
  int ue_n = 0, cc_n = 0, ce_n = 0, dma_n = 0;
  // Output table: mode, down, pulse, expected level, two spare bits, count
  logic [15:0] tbl [16] = '{16'hA430, 16'h8030, 16'h2030, 16'h2C10, 16'h0C10, 16'h4810,
    16'h6C10, 16'h6810, 16'hC405, 16'hC010, 16'hD410, 16'hD011, 16'hE005, 16'hE410,
    16'hF411, 16'hF010};

  tecc_core u_tecc_core (.*);

  // Free running bench clock, 25 ns period
  always #12.5 aclk = ~aclk;

  // Count event pulses seen at the clock edge
  always @(posedge aclk) begin
    if (update_event === 1'h1) ue_n++;
    if (counter_clear === 1'h1) cc_n++;
    if (chan_event === 1'h1) ce_n++;
    if (chan_dma_req === 1'h1) dma_n++;
  end

  // Print the tally and the verdict, then end the run
  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  // Compare seen against expected with four-state equality
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // A wait that ran out of bound counts as a mismatch
  task automatic tmo();
    err_count++;
    $display("CHECK FAILED bus_wait expected answer seen none");
    stop_test();
  endtask : tmo

  // Let n edges pass, then sample midway so registered outputs have landed
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask : settle

  // Bus write; handshakes judged at the falling edge, before the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic ah, wh, bh;
    int n;
    bh = 1'h0;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!bh && n < 50) begin
      @(negedge aclk);
      ah = s_axi_awvalid & s_axi_awready;
      wh = s_axi_wvalid & s_axi_wready;
      bh = (s_axi_bvalid === 1'h1);
      if (bh) chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'h0;
      if (wh) s_axi_wvalid <= 1'h0;
      n++;
    end
    s_axi_bready <= 1'h0;
    if (!bh) tmo();
  endtask : wr

  // Bus read with expected data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic ah, rh;
    int n;
    rh = 1'h0;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!rh && n < 50) begin
      @(negedge aclk);
      ah = s_axi_arvalid & s_axi_arready;
      rh = (s_axi_rvalid === 1'h1);
      if (rh) begin
        chk("rdata", s_axi_rdata, exp);
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
      end
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 1'h0;
      n++;
    end
    s_axi_rready <= 1'h0;
    if (!rh) tmo();
  endtask : rd

  // Main sequence
  initial begin
    logic [15:0] r;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    rd(TECC_OFF_SWEVT, 32'h00000000, TECC_RESP_OKAY);
    rd(TECC_OFF_CHCTL, TECC_RESET, TECC_RESP_OKAY);
    rd(8'h40, 32'h00000000, TECC_RESP_SLVERR);
    wr(TECC_OFF_CMPV, 32'h00000010, 4'hF, TECC_RESP_OKAY);
    // Every output mode, counter pulsed or parked around the compare value
    // Shadow stays on so PWM never runs with an unshadowed compare value
    for (int i = 0; i < 16; i++) begin
      r = tbl[i];
      wr(TECC_OFF_CHCTL, {25'h0, r[15:13], 4'h8}, 4'hF, TECC_RESP_OKAY);
      counter_value <= {8'h00, r[7:0]};
      count_down <= r[12];
      if (r[11]) begin
        @(posedge aclk);
        counter_value <= 16'h0030;
      end
      settle(3);
      chk("prepared_output", {31'h0, prepared_output}, {31'h0, r[10]});
    end
    // Fast mode: one trigger edge acts as a match for one cycle
    wr(TECC_OFF_CHCTL, 32'h0000006C, 4'hF, TECC_RESP_OKAY);
    counter_value <= 16'h0005;
    count_down <= 1'h0;
    settle(2);
    chk("fast_before", {31'h0, prepared_output}, 32'h00000001);
    @(posedge aclk);
    trig_edge <= 1'h1;
    @(posedge aclk);
    trig_edge <= 1'h0;
    @(negedge aclk);
    chk("fast_match", {31'h0, prepared_output}, 32'h00000000);
    settle(1);
    chk("fast_after", {31'h0, prepared_output}, 32'h00000001);
    // Shadowed compare value waits for the update event
    wr(TECC_OFF_CHCTL, 32'h00000068, 4'hF, TECC_RESP_OKAY);
    counter_value <= 16'h0015;
    count_down <= 1'h0;
    wr(TECC_OFF_CMPV, 32'h00000020, 4'hF, TECC_RESP_OKAY);
    settle(2);
    chk("shadow_hold", {31'h0, prepared_output}, 32'h00000000);
    wr(TECC_OFF_SWEVT, 32'h00000001, 4'hF, TECC_RESP_OKAY);
    settle(3);
    chk("shadow_load", {31'h0, prepared_output}, 32'h00000001);
    chk("update_count", ue_n, 32'h00000001);
    chk("clear_count", cc_n, 32'h00000001);
    // Software channel event in output mode, both requests enabled
    chan_irq_enable <= 1'h1;
    chan_dma_enable <= 1'h1;
    wr(TECC_OFF_SWEVT, 32'h00000002, 4'hF, TECC_RESP_OKAY);
    settle(1);
    chk("chan_event_count", ce_n, 32'h00000001);
    chk("dma_count", dma_n, 32'h00000001);
    chk("flag", {31'h0, chan_capcmp_flag}, 32'h00000001);
    chk("irq", {31'h0, chan_irq}, 32'h00000001);
    rd(TECC_OFF_SWEVT, 32'h00000000, TECC_RESP_OKAY);
    rd(TECC_OFF_STAT, 32'h00000002, TECC_RESP_OKAY);
    flag_clear <= 1'h1;
    @(posedge aclk);
    flag_clear <= 1'h0;
    @(negedge aclk);
    chk("flag_cleared", {31'h0, chan_capcmp_flag}, 32'h00000000);
    chk("irq_cleared", {31'h0, chan_irq}, 32'h00000000);
    // Input mode: filter and prescaler fields, capture and overcapture
    wr(TECC_OFF_CHCTL, 32'h000000DD, 4'hF, TECC_RESP_OKAY);
    settle(1);
    chk("filter", {28'h0, capture_filter}, 32'h0000000D);
    chk("prescaler", {30'h0, capture_prescaler}, 32'h00000003);
    counter_value <= 16'h1234;
    wr(TECC_OFF_SWEVT, 32'h00000002, 4'hF, TECC_RESP_OKAY);
    counter_value <= 16'h2345;
    wr(TECC_OFF_SWEVT, 32'h00000002, 4'hF, TECC_RESP_OKAY);
    settle(1);
    chk("overcapture", {31'h0, chan_overcapture_flag}, 32'h00000001);
    rd(TECC_OFF_CMPV, 32'h00002345, TECC_RESP_OKAY);
    settle(1);
    chk("flag_after_read", {31'h0, chan_capcmp_flag}, 32'h00000000);
    // Direction locked while the channel is enabled
    chan_enable <= 1'h1;
    wr(TECC_OFF_CHCTL, 32'h000000DC, 4'hF, TECC_RESP_OKAY);
    rd(TECC_OFF_CHCTL, 32'h000000DD, TECC_RESP_OKAY);
    chan_enable <= 1'h0;
    // Partial word write refused without effect, unmapped write refused
    wr(TECC_OFF_CHCTL, 32'h00000050, 4'h3, TECC_RESP_SLVERR);
    rd(TECC_OFF_CHCTL, 32'h000000DD, TECC_RESP_OKAY);
    wr(8'h44, 32'h00000001, 4'hF, TECC_RESP_SLVERR);
    stop_test();
  end
endmodule : tecc_core_tb
